// ==== mcra_regs.vh ====
// constants for the monitor channel register access block
`ifndef MCRA_REGS_VH
`define MCRA_REGS_VH
`define MCRA_NUM_CH 4
`define MCRA_HDR_WRITE 8'hc8
`define MCRA_HDR_READ 8'hc0
`define MCRA_POS_MON_FIRST 5'h10
`define MCRA_POS_MON_LAST 5'h17
`define MCRA_POS_MR 5'h1e
`define MCRA_POS_MX 5'h1f
`define MCRA_ADDR_LINE_PORT_SELECT 8'h00
`define MCRA_ADDR_STATUS 8'h01
`define MCRA_LINE_PORT_SELECT_RST 2'h0
`define MCRA_EOM_FRAMES 2'h2
`define MCRA_ABORT_FRAMES 2'h2
`define MCRA_IDLE_BYTE 8'hff
`endif

// ==== mcra_monitor.v ====
// monitor channel handshake and register access command decoder
//
// Behaviour
// - ack in third frame if frames one and two agree, else once two agree.
// - device captures the new byte in the frame the transmit flag rises.
// - device releases read ack in the frame after the flag goes inactive.
// - re-ack exactly one frame after release if bytes agree, else abort.
// - on end of message the device keeps read ack inactive.
// - third byte uses the same pulse, capture and ack steps as the second.
// - device answers as soon as possible with directions reversed.
// - device sends its next byte in the frame right after the ack.
// - abort holds read ack inactive two frames: no end after two bytes (three for c8), or mismatch.
// - device resends its outstanding register answer after a failure.
// - register access commands go before other monitor commands.
// - line registers use the bank chosen by line port select; one channel at once.
// - three bytes with header c8: write address and value.
// - two bytes with header c0: read request for the address.
// - read answer is three bytes: header c0, address, contents.
// - monitor byte in slot bits 17 to 24, read ack bit 31, transmit bit 32.
// - both handshake bits active low; sender repeats its byte until acked.
// - a direction is idle after both bits high two or more frames.
// - sample bus data on data clock falling edge; frame sync starts frames.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mcra_regs.vh"

module mcra_monitor (
  input wire ref_clk_in,          // 40 MHz system clock
  input wire rstn_in,             // synchronous reset, active low
  input wire frame_sync_in,       // 8 kHz frame sync pin
  input wire bus_data_clock_in,   // bus data clock pin, twice bit rate
  input wire bus_data_in,         // downstream bus data pin
  output wire bus_data_out,       // upstream bus data
  output wire bus_data_oe_out,    // high while upstream data is driven
  input wire [7:0] loc_addr_in,   // local register port address
  input wire [7:0] loc_wdata_in,  // local register port write data
  input wire loc_wr_in,           // local write strobe
  input wire loc_rd_in,           // local read strobe
  output wire [7:0] loc_rdata_out // local read data, cycle after strobe
);

  localparam RX_IDLE = 3'h0;
  localparam RX_FIRST = 3'h1;
  localparam RX_ACK = 3'h2;
  localparam RX_REL = 3'h3;
  localparam RX_ABORT = 3'h4;
  localparam TX_IDLE = 3'h0;
  localparam TX_LOAD = 3'h1;
  localparam TX_GAP = 3'h2;
  localparam TX_WAIT = 3'h3;
  localparam TX_EOM = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  reg [2:0] s1_reg;
  reg [2:0] s2_reg;
  reg [2:0] s3_reg;
  reg [2:0] filt_reg;
  reg [2:0] filt_d_reg;
  always @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
      filt_reg <= 3'h0;
      filt_d_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= {bus_data_in, bus_data_clock_in, frame_sync_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
      filt_d_reg <= filt_reg;
    end
  end

  wire tick = filt_reg[0] & ~filt_d_reg[0];
  wire dcl_fall = ~filt_reg[1] & filt_d_reg[1];
  wire dcl_rise = filt_reg[1] & ~filt_d_reg[1];
  wire din = filt_reg[2];

  ////////////////////////////////////////////////////////////////////////
  // frame position: two clock edges per bit, 32 bits per channel slot
  reg [8:0] edge_cnt_reg;
  reg dout_reg;
  reg oe_reg;
  wire bit_smp = dcl_fall & edge_cnt_reg[0] & ~edge_cnt_reg[8];
  wire [1:0] slot_ch = edge_cnt_reg[7:6];
  wire [4:0] slot_pos = edge_cnt_reg[5:1];
  wire [31:0] up_byte_w;
  wire [3:0] up_mr_w;
  wire [3:0] up_mx_w;
  reg up_bit;
  always @*
  begin
    up_bit = 1'b1;
    if (slot_pos == `MCRA_POS_MR)
      up_bit = up_mr_w[slot_ch];
    else if (slot_pos == `MCRA_POS_MX)
      up_bit = up_mx_w[slot_ch];
    else if (slot_pos >= `MCRA_POS_MON_FIRST && slot_pos <= `MCRA_POS_MON_LAST)
      up_bit = up_byte_w[{slot_ch, 3'h7 - slot_pos[2:0]}];
  end

  always @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      edge_cnt_reg <= 9'h100;
      dout_reg <= 1'b1;
      oe_reg <= 1'b0;
    end
    else
    begin
      if (tick)
        edge_cnt_reg <= 9'h000;
      else if (dcl_fall && !edge_cnt_reg[8])
        edge_cnt_reg <= edge_cnt_reg + 9'h001;
      // drive on the rising edge so the far end sees a settled bit
      if (dcl_rise && !edge_cnt_reg[0])
      begin
        dout_reg <= up_bit;
        // bit 0 starts on the frame tick itself, while the count still reads done
        oe_reg <= tick | ~edge_cnt_reg[8];
      end
    end
  end
  assign bus_data_out = dout_reg;
  assign bus_data_oe_out = oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // register map: common page plus four banked line-interface pages
  reg [7:0] mem_common [0:127];
  reg [7:0] mem_line [0:511];
  reg [1:0] line_port_select_reg;
  reg [7:0] loc_rdata_reg;
  wire [3:0] wr_req_w;
  wire [31:0] wr_addr_w;
  wire [31:0] wr_data_w;
  wire [7:0] busy_w;

  function [7:0] map_read;
    input [7:0] a;
    begin
      if (a[7])
        map_read = mem_line[{line_port_select_reg, a[6:0]}];
      else if (a == `MCRA_ADDR_LINE_PORT_SELECT)
        map_read = {6'h00, line_port_select_reg};
      else if (a == `MCRA_ADDR_STATUS)
        map_read = busy_w;
      else
        map_read = mem_common[a[6:0]];
    end
  endfunction

  // one write per cycle; the lowest channel with a write request wins, then the local port
  reg wr_en;
  reg [7:0] wr_a;
  reg [7:0] wr_d;
  integer i;
  always @*
  begin
    wr_en = loc_wr_in;
    wr_a = loc_addr_in;
    wr_d = loc_wdata_in;
    for (i = `MCRA_NUM_CH - 1; i >= 0; i = i - 1)
    begin
      if (wr_req_w[i])
      begin
        wr_en = 1'b1;
        wr_a = wr_addr_w[i*8 +: 8];
        wr_d = wr_data_w[i*8 +: 8];
      end
    end
  end

  always @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      line_port_select_reg <= `MCRA_LINE_PORT_SELECT_RST;
      loc_rdata_reg <= 8'h00;
    end
    else
    begin
      if (wr_en && wr_a == `MCRA_ADDR_LINE_PORT_SELECT)
        line_port_select_reg <= wr_d[1:0];
      loc_rdata_reg <= loc_rd_in ? map_read(loc_addr_in) : 8'h00;
    end
    if (wr_en && wr_a[7])
      mem_line[{line_port_select_reg, wr_a[6:0]}] <= wr_d;
    else if (wr_en && wr_a != `MCRA_ADDR_LINE_PORT_SELECT && wr_a != `MCRA_ADDR_STATUS)
      mem_common[wr_a[6:0]] <= wr_d;
  end
  assign loc_rdata_out = loc_rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // per-channel handshake engines; they share the register map and its single write port
  genvar g;
  generate
    for (g = 0; g < `MCRA_NUM_CH; g = g + 1)
    begin : chan
      reg [7:0] cap_byte_reg;
      reg cap_mx_reg;
      reg cap_mr_reg;
      reg [2:0] rx_state_reg;
      reg [7:0] rx_last_reg;
      reg [23:0] rx_buf_reg;
      reg [1:0] rx_cnt_reg;
      reg [1:0] rx_hi_reg;
      reg mr_up_reg;
      reg wr_req_reg;
      reg [7:0] wr_addr_reg;
      reg [7:0] wr_data_reg;
      reg pend_reg;
      reg [7:0] ans_addr_reg;
      reg [7:0] ans_data_reg;
      reg [2:0] tx_state_reg;
      reg [1:0] tx_idx_reg;
      reg [7:0] tx_byte_reg;
      reg mx_up_reg;
      reg tx_seen_hi_reg;
      reg [1:0] tx_cnt_reg;
      // the header shifts up as bytes arrive, so pick it by the byte count
      wire [7:0] rx_hdr = (rx_cnt_reg == 2'h1) ? rx_buf_reg[7:0] : rx_buf_reg[15:8];
      wire [1:0] rx_max = (rx_hdr == `MCRA_HDR_WRITE) ? 2'h3 : 2'h2;
      wire [7:0] ans_byte = (tx_idx_reg == 2'h0) ? ans_addr_reg : ans_data_reg;

      always @(posedge ref_clk_in)
      begin
        if (!rstn_in)
        begin
          cap_byte_reg <= `MCRA_IDLE_BYTE;
          cap_mx_reg <= 1'b1;
          cap_mr_reg <= 1'b1;
          rx_state_reg <= RX_IDLE;
          rx_last_reg <= 8'h00;
          rx_buf_reg <= 24'h000000;
          rx_cnt_reg <= 2'h0;
          rx_hi_reg <= 2'h0;
          mr_up_reg <= 1'b1;
          wr_req_reg <= 1'b0;
          wr_addr_reg <= 8'h00;
          wr_data_reg <= 8'h00;
          pend_reg <= 1'b0;
          ans_addr_reg <= 8'h00;
          ans_data_reg <= 8'h00;
          tx_state_reg <= TX_IDLE;
          tx_idx_reg <= 2'h0;
          tx_byte_reg <= `MCRA_IDLE_BYTE;
          mx_up_reg <= 1'b1;
          tx_seen_hi_reg <= 1'b0;
          tx_cnt_reg <= 2'h0;
        end
        else
        begin
          wr_req_reg <= 1'b0;
          if (bit_smp && slot_ch == g)
          begin
            if (slot_pos >= `MCRA_POS_MON_FIRST && slot_pos <= `MCRA_POS_MON_LAST)
              cap_byte_reg <= {cap_byte_reg[6:0], din};
            if (slot_pos == `MCRA_POS_MR)
              cap_mr_reg <= din;
            if (slot_pos == `MCRA_POS_MX)
              cap_mx_reg <= din;
          end
          if (tick)
          begin
            // receive direction, flags active low
            case (rx_state_reg)
              RX_IDLE:
                if (!cap_mx_reg)
                begin
                  rx_last_reg <= cap_byte_reg;
                  rx_cnt_reg <= 2'h0;
                  rx_state_reg <= RX_FIRST;
                end
              RX_FIRST:
                if (cap_mx_reg)
                  rx_state_reg <= RX_IDLE;
                else if (cap_byte_reg == rx_last_reg)
                begin
                  mr_up_reg <= 1'b0;
                  rx_buf_reg <= {16'h0000, cap_byte_reg};
                  rx_cnt_reg <= 2'h1;
                  rx_state_reg <= RX_ACK;
                end
                else
                  rx_last_reg <= cap_byte_reg;
              RX_ACK:
                if (cap_mx_reg)
                begin
                  rx_last_reg <= cap_byte_reg;
                  mr_up_reg <= 1'b1;
                  rx_state_reg <= RX_REL;
                end
              RX_REL:
                if (cap_mx_reg)
                begin
                  // second inactive frame: end of message, ack stays off
                  rx_state_reg <= RX_IDLE;
                  // only the register class is served, so it never queues
                  if (rx_cnt_reg == 2'h3 && rx_buf_reg[23:16] == `MCRA_HDR_WRITE)
                  begin
                    wr_req_reg <= 1'b1;
                    wr_addr_reg <= rx_buf_reg[15:8];
                    wr_data_reg <= rx_buf_reg[7:0];
                  end
                  else if (rx_cnt_reg == 2'h2 && rx_buf_reg[15:8] == `MCRA_HDR_READ)
                  begin
                    pend_reg <= 1'b1;
                    ans_addr_reg <= rx_buf_reg[7:0];
                    ans_data_reg <= map_read(rx_buf_reg[7:0]);
                  end
                  // any other length or header falls through untouched
                end
                else if (cap_byte_reg == rx_last_reg && rx_cnt_reg < rx_max)
                begin
                  mr_up_reg <= 1'b0;
                  rx_buf_reg <= {rx_buf_reg[15:0], cap_byte_reg};
                  rx_cnt_reg <= rx_cnt_reg + 2'h1;
                  rx_state_reg <= RX_ACK;
                end
                else
                begin
                  rx_hi_reg <= 2'h0;
                  rx_state_reg <= RX_ABORT;
                end
              RX_ABORT:
              begin
                mr_up_reg <= 1'b1;
                if (!cap_mx_reg)
                  rx_hi_reg <= 2'h0;
                else if (rx_hi_reg == `MCRA_ABORT_FRAMES - 2'h1)
                  rx_state_reg <= RX_IDLE;
                else
                  rx_hi_reg <= rx_hi_reg + 2'h1;
              end
              default:
                rx_state_reg <= RX_IDLE;
            endcase
            // transmit direction
            case (tx_state_reg)
              TX_IDLE:
                if (pend_reg)
                begin
                  tx_byte_reg <= `MCRA_HDR_READ;
                  mx_up_reg <= 1'b0;
                  tx_idx_reg <= 2'h0;
                  tx_state_reg <= TX_LOAD;
                end
              TX_LOAD:
                if (!cap_mr_reg)
                begin
                  tx_byte_reg <= ans_byte;
                  mx_up_reg <= 1'b1;
                  tx_state_reg <= TX_GAP;
                end
              TX_GAP:
              begin
                mx_up_reg <= 1'b0;
                tx_seen_hi_reg <= 1'b0;
                tx_cnt_reg <= 2'h0;
                tx_state_reg <= TX_WAIT;
              end
              TX_WAIT:
                if (!cap_mr_reg && tx_seen_hi_reg)
                begin
                  mx_up_reg <= 1'b1;
                  if (tx_idx_reg == 2'h1)
                  begin
                    pend_reg <= 1'b0;
                    tx_cnt_reg <= 2'h0;
                    tx_state_reg <= TX_EOM;
                  end
                  else
                  begin
                    tx_byte_reg <= ans_data_reg;
                    tx_idx_reg <= tx_idx_reg + 2'h1;
                    tx_state_reg <= TX_GAP;
                  end
                end
                else if (cap_mr_reg)
                begin
                  tx_seen_hi_reg <= 1'b1;
                  tx_cnt_reg <= tx_cnt_reg + 2'h1;
                  // second released frame: the far end aborted, answer stays pending
                  if (tx_cnt_reg == 2'h1)
                  begin
                    mx_up_reg <= 1'b1;
                    tx_cnt_reg <= 2'h0;
                    tx_state_reg <= TX_EOM;
                  end
                end
              TX_EOM:
                if (tx_cnt_reg == `MCRA_EOM_FRAMES - 2'h1)
                  tx_state_reg <= TX_IDLE;
                else
                  tx_cnt_reg <= tx_cnt_reg + 2'h1;
              default:
                tx_state_reg <= TX_IDLE;
            endcase
          end
        end
      end

      assign up_byte_w[g*8 +: 8] = tx_byte_reg;
      assign up_mr_w[g] = mr_up_reg;
      assign up_mx_w[g] = mx_up_reg;
      assign wr_req_w[g] = wr_req_reg;
      assign wr_addr_w[g*8 +: 8] = wr_addr_reg;
      assign wr_data_w[g*8 +: 8] = wr_data_reg;
      assign busy_w[g] = (rx_state_reg != RX_IDLE);
      assign busy_w[g+4] = (tx_state_reg != TX_IDLE);
    end
  endgenerate

endmodule
`default_nettype wire

// ==== mcra_monitor_sva.sv ====
// port checker for the monitor register access block
`timescale 1ns/1ps
`default_nettype none
`include "mcra_regs.vh"
module mcra_monitor_sva (
  input wire logic ref_clk_in, // system clock
  input wire logic rstn_in, // reset, active low
  input wire logic frame_sync_in, // frame sync pin
  input wire logic bus_data_clock_in, // data clock pin
  input wire logic bus_data_out, // upstream data
  input wire logic bus_data_oe_out, // upstream enable
  input wire logic [7:0] loc_addr_in, // local address
  input wire logic [7:0] loc_wdata_in, // local write data
  input wire logic loc_wr_in, // write strobe
  input wire logic loc_rd_in, // read strobe
  input wire logic [7:0] loc_rdata_out // read data
);
  logic dcl_d;
  logic [3:0] since_rise;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // raw edge finder; the design sees the pin some cycles later
  always @(posedge ref_clk_in)
  begin
    dcl_d <= bus_data_clock_in;
    since_rise <= (bus_data_clock_in && !dcl_d) ? 4'h0 : since_rise + 4'h1;
  end
  //////////////////////////////////////////////////
  sequence s_wr_rd;
    loc_wr_in ##1 loc_rd_in && loc_addr_in == $past(loc_addr_in)
      && loc_addr_in > `MCRA_ADDR_STATUS;
  endsequence
  chk_rd_data_zero:
    assert property (!$past(loc_rd_in) |-> loc_rdata_out == 8'h00)
    else $error("read data outside read slot");
  chk_wr_rd_back:
    assert property (s_wr_rd |=> loc_rdata_out == $past(loc_wdata_in, 2))
    else $error("read after write mismatch");
  chk_sel_width:
    assert property (loc_rd_in && loc_addr_in == `MCRA_ADDR_LINE_PORT_SELECT |=> loc_rdata_out[7:2] == 6'h00)
    else $error("port select upper bits set");
  chk_reset_idle:
    assert property ($rose(rstn_in) |-> !bus_data_oe_out && bus_data_out && loc_rdata_out == 8'h00)
    else $error("outputs not idle after reset");
  chk_oe_after_reset:
    assert property ($rose(rstn_in) |-> !bus_data_oe_out [*3])
    else $error("upstream driven before framing");
  chk_oe_after_sync:
    assert property ($rose(bus_data_oe_out) |-> $past(frame_sync_in, 4))
    else $error("upstream enabled away from frame start");
  chk_oe_holds:
    assert property ($rose(bus_data_oe_out) |-> bus_data_oe_out [*8])
    else $error("upstream enable glitch");
  chk_data_at_rise:
    assert property ($changed(bus_data_out) |-> since_rise >= 4'h2 && since_rise <= 4'h6)
    else $error("upstream bit changed off rising clock");
  cover property (s_wr_rd);
  cover property ($rose(bus_data_oe_out));
  cover property (loc_rd_in && loc_addr_in == `MCRA_ADDR_STATUS);
endmodule
`default_nettype wire

// ==== mcra_ctrl_model.sv ====
// layer-2 controller model: bus framing and the channel 0 slot
`timescale 1ns/1ps
`default_nettype none
module mcra_ctrl_model (
  input wire logic [7:0] dn_byte_in, // monitor byte to send
  input wire logic dn_flag_in, // transmit flag to send, low active
  input wire logic dn_ack_in, // read ack to send, low active
  input wire logic up_data_in, // upstream data
  input wire logic up_oe_in, // device drives upstream
  output logic frame_sync_out, // frame start
  output logic data_clock_out, // bus data clock
  output logic dn_data_out, // downstream data
  output logic [7:0] up_byte_out, // device byte, last frame
  output logic up_flag_out, // device transmit flag, last frame
  output logic up_ack_out, // device read ack, last frame
  output logic [15:0] frame_cnt_out // completed frames
);
  logic [31:0] slot;
  logic [31:0] rx;
  int b;
  initial
  begin
    data_clock_out = 1'b0;
    forever #100 data_clock_out = ~data_clock_out;
  end
  //////////////////////////////////////////////////
  initial
  begin
    frame_sync_out = 1'b0;
    dn_data_out = 1'b1;
    {up_byte_out, up_flag_out, up_ack_out} = 10'h3ff;
    frame_cnt_out = 16'h0000;
    rx = 32'hffffffff;
    forever
    begin
      for (b = 0; b < 128; b++)
      begin
        @(posedge data_clock_out);
        // slot latched late so the bench can update it after a frame ends
        if (b == 0)
          slot = {16'hffff, dn_byte_in, 6'h3f, dn_ack_in, dn_flag_in};
        frame_sync_out <= (b == 0);
        dn_data_out <= (b < 32) ? slot[31 - b] : 1'b1;
        @(posedge data_clock_out);
        frame_sync_out <= 1'b0;
        @(negedge data_clock_out);
        // released line reads high through the pull-up
        if (b < 32)
          rx[31 - b] = up_oe_in ? up_data_in : 1'b1;
      end
      up_byte_out = rx[15:8];
      up_ack_out = rx[1];
      up_flag_out = rx[0];
      frame_cnt_out = frame_cnt_out + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== test_monitor_channel_register_access.sv ====
// self-checking bench for the monitor register access block
`timescale 1ns/1ps
`default_nettype none
`include "mcra_regs.vh"
module test_monitor_channel_register_access;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic loc_wr = 1'b0;
  logic loc_rd = 1'b0;
  logic rd_seen = 1'b0;
  logic dn_flag = 1'b1;
  logic dn_ack = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] dn_byte = 8'hff;
  logic fs, bus_data_clock, dn_data, up_data, up_oe, up_flag, up_ack;
  logic [7:0] rdata, up_byte, v, w, d;
  logic [15:0] frame_cnt;
  logic [7:0] rd_q [$];
  int error_cnt = 0;
  int checked = 0;
  mcra_monitor i_mcra_monitor (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .frame_sync_in(fs),
    .bus_data_clock_in(bus_data_clock), .bus_data_in(dn_data), .bus_data_out(up_data),
    .bus_data_oe_out(up_oe), .loc_addr_in(addr), .loc_wdata_in(wdata),
    .loc_wr_in(loc_wr), .loc_rd_in(loc_rd), .loc_rdata_out(rdata));
  mcra_ctrl_model i_mcra_ctrl_model (
    .dn_byte_in(dn_byte), .dn_flag_in(dn_flag), .dn_ack_in(dn_ack),
    .up_data_in(up_data), .up_oe_in(up_oe), .frame_sync_out(fs),
    .data_clock_out(bus_data_clock), .dn_data_out(dn_data), .up_byte_out(up_byte),
    .up_flag_out(up_flag), .up_ack_out(up_ack), .frame_cnt_out(frame_cnt));
  initial
  begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  //////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes stay up until the next call, so back-to-back cycles never glitch
  task cyc(input logic wr_en, rd_en, input logic [7:0] a, dat);
    loc_wr <= wr_en;
    loc_rd <= rd_en;
    addr <= a;
    wdata <= dat;
    if (rd_en)
      rd_q.push_back(dat);
    @(posedge ref_clk_in);
  endtask
  task fw;
    @(frame_cnt);
  endtask
  task send(input logic [7:0] m0, m1, m2, input int n, input logic ab);
    logic [7:0] m [3];
    int i;
    m = '{m0, m1, m2};
    dn_byte = m[0];
    dn_flag = 1'b0;
    repeat (3) fw;
    chk({7'h0, up_ack}, 8'h00);
    for (i = 1; i < n; i++)
    begin
      dn_byte = m[i];
      dn_flag = 1'b1;
      fw;
      dn_flag = 1'b0;
      fw;
      chk({7'h0, up_ack}, 8'h01);
      fw;
      chk({7'h0, up_ack}, {7'h0, ab && i == n - 1});
    end
    dn_flag = 1'b1;
    repeat (2) fw;
    chk({7'h0, up_ack}, 8'h01);
    fw;
    @(posedge ref_clk_in);
  endtask
  task recv(input logic [7:0] a, dat);
    logic [7:0] e [3];
    int i;
    e = '{`MCRA_HDR_READ, a, dat};
    for (i = 0; i < 8 && up_flag !== 1'b0; i++)
      fw;
    chk({7'h0, up_flag}, 8'h00);
    chk(up_byte, e[0]);
    dn_ack = 1'b0;
    fw;
    for (i = 1; i < 3; i++)
    begin
      fw;
      chk({7'h0, up_flag}, 8'h01);
      chk(up_byte, e[i]);
      dn_ack = 1'b1;
      fw;
      dn_ack = 1'b0;
      fw;
    end
    fw;
    dn_ack = 1'b1;
    chk({7'h0, up_flag}, 8'h01);
    fw;
    chk({7'h0, up_flag}, 8'h01);
    @(posedge ref_clk_in);
  endtask
  task test_done;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////
  always @(posedge ref_clk_in)
  begin
    if (rd_seen)
      chk(rdata, rd_q.pop_front());
    rd_seen <= loc_rd;
  end
  initial
  begin
    #2_600_000;
    error_cnt++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    test_done;
  end
  initial
  begin
    v = $urandom(32'h90d6adc3);
    v = $urandom;
    w = $urandom;
    d = $urandom;
    repeat (5) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    cyc(0, 1, `MCRA_ADDR_LINE_PORT_SELECT, 8'h00);
    cyc(1, 0, `MCRA_ADDR_LINE_PORT_SELECT, 8'h01);
    cyc(1, 0, 8'h85, v);
    cyc(1, 0, `MCRA_ADDR_LINE_PORT_SELECT, 8'hfe);
    cyc(1, 0, 8'h85, w);
    cyc(0, 1, 8'h85, w);
    cyc(1, 0, `MCRA_ADDR_LINE_PORT_SELECT, 8'h01);
    cyc(0, 1, 8'h85, v);
    cyc(0, 1, `MCRA_ADDR_LINE_PORT_SELECT, 8'h01);
    cyc(1, 0, `MCRA_ADDR_STATUS, 8'hff);
    cyc(0, 1, `MCRA_ADDR_STATUS, 8'h00);
    cyc(1, 0, 8'h02, w);
    cyc(0, 1, 8'h02, w);
    cyc(0, 0, 8'h00, 8'h00);
    repeat (2) fw;
    send(`MCRA_HDR_WRITE, 8'h03, d, 3, 1'b0);
    cyc(0, 1, 8'h03, d);
    cyc(0, 0, 8'h00, 8'h00);
    send(`MCRA_HDR_READ, 8'h03, 8'h00, 2, 1'b0);
    recv(8'h03, d);
    send(`MCRA_HDR_READ, 8'h03, 8'h5a, 3, 1'b1);
    chk({6'h00, up_flag, up_ack}, 8'h03);
    cyc(0, 1, 8'h03, d);
    cyc(0, 0, 8'h00, 8'h00);
    repeat (2) @(posedge ref_clk_in);
    test_done;
  end
endmodule
bind mcra_monitor mcra_monitor_sva i_mcra_monitor_sva (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .frame_sync_in(frame_sync_in),
  .bus_data_clock_in(bus_data_clock_in), .bus_data_out(bus_data_out),
  .bus_data_oe_out(bus_data_oe_out), .loc_addr_in(loc_addr_in),
  .loc_wdata_in(loc_wdata_in), .loc_wr_in(loc_wr_in), .loc_rd_in(loc_rd_in),
  .loc_rdata_out(loc_rdata_out));
`default_nettype wire
